// ### hdl/abu_consts.svh
// register map, field positions, reset values, break opcode and vectors of the address breakpoint unit
// How it works
// - with breaks enabled, a match of the internal address bus in a fetch cycle against the breakpoint address raises a break request.
// - bit 7 of the control register enables 16-bit match breaks, reads back, clears on a zero write and on reset.
// - on a break the cpu takes the software interrupt opcode and the normal or monitor-mode vector.
// - a break starts at the end of the current instruction, or at once if the match falls on its last cycle.
// - every breakpoint address match sets the break active flag.
// - writing one to the break active flag raises a break by itself, with no match needed.
// - writing zero to the break active flag or reset clears it, and software clears it before leaving the routine.
// - high and low address bytes hold the compare address and clear to zero on reset.
// - a return-from-interrupt in the break routine ends the break state.
// - while a break is active the timer counters are held stopped.
// - during a break the watchdog is disabled while the test level is present on the reset pin.
// - the comparison stays live in wait mode so that a match ends the wait.
// - the break-wait flag sets when a break ends wait mode, reads back and clears on a zero write or reset.
// - a break wakes the device from stop and sets the low-power exit flag.
// - in the break state, status writes clear status bits only while the clear-flag enable is set.
`ifndef ABU_CONSTS_SVH
`define ABU_CONSTS_SVH
`define ABU_OFS_CTRL 3'h0
`define ABU_OFS_ADRH 3'h1
`define ABU_OFS_ADRL 3'h2
`define ABU_OFS_WAKE 3'h3
`define ABU_OFS_FCLR 3'h4
`define ABU_OFS_IRQS 3'h5
`define ABU_OFS_IRQM 3'h6
`define ABU_BIT_ENABLE 7
`define ABU_BIT_ACTIVE 6
`define ABU_BIT_WAIT 1
`define ABU_BIT_LPEXIT 0
`define ABU_BIT_CLREN 7
`define ABU_RST_BYTE 8'h00
`define ABU_SWI_OPCODE 8'h83
`define ABU_VEC_NORMAL 16'hFFFC
`define ABU_VEC_MONITOR 16'hFEFC
`endif

// ### hdl/abu_pkg.sv
// types of the address breakpoint unit
package abu_pkg;
   typedef enum logic [1:0] {ABU_IDLE, ABU_PEND, ABU_BREAK} abu_state_t;
   typedef struct packed {
      abu_state_t st;
      logic enable;
      logic active;
      logic bwait;
      logic lpexit;
      logic clren;
      logic [7:0] adrh;
      logic [7:0] adrl;
      logic [7:0] rdata;
      logic [2:0] irq_st;
      logic [2:0] irq_mk;
      logic was_wait;
   } abu_regs_t;
endpackage : abu_pkg

// ### hdl/abu_break_unit.sv
// address breakpoint unit: compare, break sequencing, low-power exits and register file
`include "abu_consts.svh"
module abu_break_unit
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_fetch,
   input wire logic cpu_last_cycle,
   input wire logic cpu_rti,
   input wire logic cpu_in_wait,
   input wire logic cpu_in_stop,
   input wire logic monitor_mode,
   input wire logic test_level_voltage,
   output logic break_req,
   output logic [7:0] software_interrupt_opcode,
   output logic [15:0] break_vector,
   output logic low_power_wake,
   output logic timer_counters_stop,
   output logic watchdog_disable,
   output logic status_clear_allow,
   output logic irq
);
   import abu_pkg::*;

   abu_regs_t r_r;
   abu_regs_t r_nxt;
   logic match;
   logic sw_break;
   logic boundary;
   logic take;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      match = r_r.enable && cpu_fetch && (cpu_addr == {r_r.adrh, r_r.adrl});
      sw_break = reg_wr && (reg_addr == `ABU_OFS_CTRL) && reg_wdata[`ABU_BIT_ACTIVE];
      boundary = cpu_last_cycle || cpu_in_wait || cpu_in_stop;
      take = (match || sw_break || r_r.st == ABU_PEND) && boundary;
      r_nxt = r_r;
      r_nxt.rdata = 8'h00;
      case (r_r.st)
         ABU_IDLE:
         begin
            if (match || sw_break)
            begin
               r_nxt.st = take ? ABU_BREAK : ABU_PEND;
               r_nxt.was_wait = cpu_in_wait;
            end
         end
         ABU_PEND:
         begin
            if (cpu_in_wait)
            begin
               r_nxt.was_wait = 1'b1;
            end
            if (take)
            begin
               r_nxt.st = ABU_BREAK;
            end
         end
         ABU_BREAK:
         begin
            if (cpu_rti)
            begin
               r_nxt.st = ABU_IDLE;
            end
         end
         default:
         begin
            r_nxt.st = ABU_IDLE;
         end
      endcase
      if (reg_wr)
      begin
         case (reg_addr)
            `ABU_OFS_CTRL:
            begin
               r_nxt.enable = reg_wdata[`ABU_BIT_ENABLE];
               r_nxt.active = reg_wdata[`ABU_BIT_ACTIVE];
            end
            `ABU_OFS_ADRH:
            begin
               r_nxt.adrh = reg_wdata;
            end
            `ABU_OFS_ADRL:
            begin
               r_nxt.adrl = reg_wdata;
            end
            `ABU_OFS_WAKE:
            begin
               // status clears obey the break-state guard
               if (status_clear_allow)
               begin
                  r_nxt.bwait = r_r.bwait & reg_wdata[`ABU_BIT_WAIT];
                  r_nxt.lpexit = r_r.lpexit & reg_wdata[`ABU_BIT_LPEXIT];
               end
            end
            `ABU_OFS_FCLR:
            begin
               r_nxt.clren = reg_wdata[`ABU_BIT_CLREN];
            end
            `ABU_OFS_IRQS:
            begin
               if (status_clear_allow)
               begin
                  r_nxt.irq_st = r_r.irq_st & ~reg_wdata[2:0];
               end
            end
            `ABU_OFS_IRQM:
            begin
               r_nxt.irq_mk = reg_wdata[2:0];
            end
            default:
            begin
            end
         endcase
      end
      // set wins over clear
      if (match)
      begin
         r_nxt.active = 1'b1;
         r_nxt.irq_st[0] = 1'b1;
      end
      if (take && r_r.st != ABU_BREAK)
      begin
         r_nxt.irq_st[1] = 1'b1;
         if (cpu_in_wait || r_r.was_wait)
         begin
            r_nxt.bwait = 1'b1;
         end
         if (cpu_in_stop)
         begin
            r_nxt.lpexit = 1'b1;
         end
      end
      if (r_r.st == ABU_BREAK && cpu_rti)
      begin
         r_nxt.irq_st[2] = 1'b1;
         r_nxt.was_wait = 1'b0;
      end
      if (reg_rd)
      begin
         case (reg_addr)
            `ABU_OFS_CTRL:
            begin
               r_nxt.rdata = {r_r.enable, r_r.active, 6'h00};
            end
            `ABU_OFS_ADRH:
            begin
               r_nxt.rdata = r_r.adrh;
            end
            `ABU_OFS_ADRL:
            begin
               r_nxt.rdata = r_r.adrl;
            end
            `ABU_OFS_WAKE:
            begin
               r_nxt.rdata = {6'h00, r_r.bwait, r_r.lpexit};
            end
            `ABU_OFS_FCLR:
            begin
               r_nxt.rdata = {r_r.clren, 7'h00};
            end
            `ABU_OFS_IRQS:
            begin
               r_nxt.rdata = {5'h00, r_r.irq_st};
            end
            `ABU_OFS_IRQM:
            begin
               r_nxt.rdata = {5'h00, r_r.irq_mk};
            end
            default:
            begin
               r_nxt.rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         r_r <= '{st: ABU_IDLE, enable: 1'b0, active: 1'b0, bwait: 1'b0, lpexit: 1'b0, clren: 1'b0,
                  adrh: `ABU_RST_BYTE, adrl: `ABU_RST_BYTE, rdata: 8'h00, irq_st: 3'h0, irq_mk: 3'h0,
                  was_wait: 1'b0};
      end
      else
      begin
         r_r <= r_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs toward the cpu and neighbours
   always_comb
   begin
      reg_rdata = r_r.rdata;
      break_req = (r_r.st == ABU_PEND) || ((r_r.st == ABU_IDLE) && (match || sw_break));
      software_interrupt_opcode = `ABU_SWI_OPCODE;
      break_vector = monitor_mode ? `ABU_VEC_MONITOR : `ABU_VEC_NORMAL;
      low_power_wake = take && (cpu_in_wait || cpu_in_stop);
      timer_counters_stop = (r_r.st == ABU_BREAK);
      watchdog_disable = (r_r.st == ABU_BREAK) && test_level_voltage;
      status_clear_allow = (r_r.st != ABU_BREAK) || r_r.clren;
      irq = |(r_r.irq_st & r_r.irq_mk);
   end

   ////////////////////////////////////////////////////////////////////////////
   break_match_a: assert property (@(posedge clk) disable iff (sys_rst) match |=> r_r.active)
      else $error("match did not set active flag");
   match_gate_a: assert property (@(posedge clk) disable iff (sys_rst) !r_r.enable |-> !match)
      else $error("match while disabled");
   pend_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      (r_r.st == ABU_PEND && !boundary) |=> r_r.st == ABU_PEND && break_req)
      else $error("request dropped before boundary");
   boundary_take_a: assert property (@(posedge clk) disable iff (sys_rst)
      (break_req && boundary) |=> r_r.st == ABU_BREAK)
      else $error("break not started at boundary");
   sw_break_a: assert property (@(posedge clk) disable iff (sys_rst)
      (r_r.st == ABU_IDLE && sw_break) |-> break_req)
      else $error("software break not requested");
   rti_end_a: assert property (@(posedge clk) disable iff (sys_rst)
      (r_r.st == ABU_BREAK && cpu_rti) |=> !timer_counters_stop)
      else $error("break not ended by return");
   wdog_off_a: assert property (@(posedge clk) disable iff (sys_rst)
      (timer_counters_stop && test_level_voltage) |-> watchdog_disable)
      else $error("watchdog not disabled");
   wait_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
      (take && cpu_in_wait && r_r.st != ABU_BREAK) |=> r_r.bwait)
      else $error("break wait flag not set");
   stop_exit_a: assert property (@(posedge clk) disable iff (sys_rst)
      (take && cpu_in_stop && r_r.st != ABU_BREAK) |=> r_r.lpexit ##0 $past(low_power_wake))
      else $error("stop exit not flagged");
   clear_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
      (timer_counters_stop && !r_r.clren) |-> !status_clear_allow)
      else $error("status clear allowed in break");
   addr_reset_a: assert property (@(posedge clk) $past(sys_rst) |-> r_r.adrh == 8'h00 && r_r.adrl == 8'h00)
      else $error("address not cleared by reset");
   vector_a: assert property (@(posedge clk) disable iff (sys_rst)
      monitor_mode |-> break_vector == 16'hFEFC)
      else $error("wrong monitor vector");

   ////////////////////////////////////////////////////////////////////////////
   // register file and reset
   adrh_write_a: assert property (@(posedge clk) disable iff (sys_rst)
      (reg_wr && reg_addr == `ABU_OFS_ADRH) |=> r_r.adrh == $past(reg_wdata))
      else $error("address high byte not written");
   adrl_write_a: assert property (@(posedge clk) disable iff (sys_rst)
      (reg_wr && reg_addr == `ABU_OFS_ADRL) |=> r_r.adrl == $past(reg_wdata))
      else $error("address low byte not written");
   enable_write_a: assert property (@(posedge clk) disable iff (sys_rst)
      (reg_wr && reg_addr == `ABU_OFS_CTRL) |=> r_r.enable == $past(reg_wdata[7]))
      else $error("enable bit not written");
   active_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      (reg_wr && reg_addr == `ABU_OFS_CTRL && !reg_wdata[6] && !match) |=> !r_r.active)
      else $error("active flag not cleared by zero write");
   active_sw_a: assert property (@(posedge clk) disable iff (sys_rst)
      sw_break |=> r_r.active)
      else $error("software break did not set active flag");
   enable_reset_a: assert property (@(posedge clk)
      $past(sys_rst) |-> !r_r.enable && !r_r.active)
      else $error("control bits not cleared by reset");
   flags_reset_a: assert property (@(posedge clk)
      $past(sys_rst) |-> !r_r.bwait && !r_r.lpexit)
      else $error("wake flags not cleared by reset");
   state_reset_a: assert property (@(posedge clk)
      $past(sys_rst) |-> r_r.st == ABU_IDLE && !timer_counters_stop)
      else $error("break state after reset");
   read_adrh_a: assert property (@(posedge clk) disable iff (sys_rst)
      (reg_rd && reg_addr == `ABU_OFS_ADRH) |=> reg_rdata == $past(r_r.adrh))
      else $error("address high byte read wrong");
   read_ctrl_a: assert property (@(posedge clk) disable iff (sys_rst)
      (reg_rd && reg_addr == `ABU_OFS_CTRL) |=> reg_rdata[7] == $past(r_r.enable))
      else $error("enable bit read wrong");
   rdata_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read cycle");

   ////////////////////////////////////////////////////////////////////////////
   // request and break sequencing
   match_req_a: assert property (@(posedge clk) disable iff (sys_rst)
      (r_r.st == ABU_IDLE && match) |-> break_req)
      else $error("match raised no request");
   no_req_break_a: assert property (@(posedge clk) disable iff (sys_rst)
      r_r.st == ABU_BREAK |-> !break_req)
      else $error("request repeated inside break");
   break_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      (r_r.st == ABU_BREAK && !cpu_rti) |=> r_r.st == ABU_BREAK)
      else $error("break left without return");
   pend_entry_a: assert property (@(posedge clk) disable iff (sys_rst)
      (r_r.st == ABU_IDLE && (match || sw_break) && !boundary) |=> r_r.st == ABU_PEND)
      else $error("request not held until boundary");
   immediate_take_a: assert property (@(posedge clk) disable iff (sys_rst)
      (r_r.st == ABU_IDLE && match && cpu_last_cycle) |=> r_r.st == ABU_BREAK)
      else $error("last cycle match not taken at once");
   idle_stays_a: assert property (@(posedge clk) disable iff (sys_rst)
      (r_r.st == ABU_IDLE && !match && !sw_break) |=> r_r.st == ABU_IDLE)
      else $error("break without cause");
   timer_start_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(timer_counters_stop) |-> $past(take))
      else $error("timers stopped without break");
   timer_run_a: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(timer_counters_stop) |-> $past(cpu_rti))
      else $error("timers released without return");
   rti_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
      (r_r.st == ABU_BREAK && cpu_rti) |=> r_r.irq_st[2])
      else $error("break end not flagged");
   match_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
      match |=> r_r.irq_st[0])
      else $error("match not flagged");
   irq_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
      r_r.irq_mk == 3'h0 |-> !irq)
      else $error("masked interrupt raised");

   ////////////////////////////////////////////////////////////////////////////
   // neighbours, low-power exits and flag protection
   wdog_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
      !timer_counters_stop |-> !watchdog_disable)
      else $error("watchdog disabled outside break");
   wdog_tlv_a: assert property (@(posedge clk) disable iff (sys_rst)
      !test_level_voltage |-> !watchdog_disable)
      else $error("watchdog disabled without test level");
   vector_normal_a: assert property (@(posedge clk) disable iff (sys_rst)
      !monitor_mode |-> break_vector == 16'hFFFC)
      else $error("wrong normal vector");
   opcode_a: assert property (@(posedge clk) disable iff (sys_rst)
      software_interrupt_opcode == `ABU_SWI_OPCODE)
      else $error("wrong break opcode");
   wake_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
      (take && cpu_in_wait) |-> low_power_wake)
      else $error("break did not end wait");
   wake_only_a: assert property (@(posedge clk) disable iff (sys_rst)
      low_power_wake |-> (cpu_in_wait || cpu_in_stop))
      else $error("wake outside low power");
   wait_match_a: assert property (@(posedge clk) disable iff (sys_rst)
      (cpu_in_wait && match && r_r.st == ABU_IDLE) |=> r_r.st == ABU_BREAK && r_r.bwait)
      else $error("match in wait not taken");
   stop_wake_a: assert property (@(posedge clk) disable iff (sys_rst)
      (cpu_in_stop && break_req) |-> low_power_wake)
      else $error("break did not end stop");
   wait_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      (r_r.bwait && !(reg_wr && reg_addr == `ABU_OFS_WAKE)) |=> r_r.bwait)
      else $error("break wait flag lost");
   wait_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      (reg_wr && reg_addr == `ABU_OFS_WAKE && !reg_wdata[1] && status_clear_allow && !take) |=> !r_r.bwait)
      else $error("break wait flag not cleared");
   lpexit_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      (r_r.lpexit && !(reg_wr && reg_addr == `ABU_OFS_WAKE)) |=> r_r.lpexit)
      else $error("low power exit flag lost");
   lpexit_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      (reg_wr && reg_addr == `ABU_OFS_WAKE && !reg_wdata[0] && status_clear_allow && !take) |=> !r_r.lpexit)
      else $error("low power exit flag not cleared");
   guard_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
      (reg_wr && reg_addr == `ABU_OFS_WAKE && !status_clear_allow && r_r.bwait) |=> r_r.bwait)
      else $error("guarded wait flag cleared");
   guard_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
      (reg_wr && reg_addr == `ABU_OFS_IRQS && !status_clear_allow && r_r.irq_st[0]) |=> r_r.irq_st[0])
      else $error("guarded status cleared");
   clear_open_a: assert property (@(posedge clk) disable iff (sys_rst)
      r_r.st != ABU_BREAK |-> status_clear_allow)
      else $error("clears blocked outside break");
   clren_open_a: assert property (@(posedge clk) disable iff (sys_rst)
      r_r.clren |-> status_clear_allow)
      else $error("clears blocked with enable set");

   match_break_c: cover property (@(posedge clk) disable iff (sys_rst) match ##[1:20] r_r.st == ABU_BREAK);
   sw_break_c: cover property (@(posedge clk) disable iff (sys_rst) sw_break ##[1:20] cpu_rti);
   wait_exit_c: cover property (@(posedge clk) disable iff (sys_rst) take && cpu_in_wait);
   stop_exit_c: cover property (@(posedge clk) disable iff (sys_rst) take && cpu_in_stop);
   pend_take_c: cover property (@(posedge clk) disable iff (sys_rst) r_r.st == ABU_PEND ##1 r_r.st == ABU_BREAK);
endmodule : abu_break_unit

// ### dv/abu_cpu_model.sv
// cpu sequencer model: three-cycle instructions, breaks taken at boundaries
module abu_cpu_model
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic break_req,
   input wire logic leave,
   input wire logic halt,
   output logic [15:0] cpu_addr,
   output logic cpu_fetch,
   output logic cpu_last_cycle,
   output logic cpu_rti
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph;
   logic [15:0] pc;
   logic in_brk;
   assign cpu_fetch = !in_brk && ph == 2'h0;
   assign cpu_last_cycle = !in_brk && ph == 2'h2;
   // address bus carries no fetch value outside fetch cycles
   assign cpu_addr = cpu_fetch ? pc : ~pc;
   always_ff @(posedge clk)
   begin
      cpu_rti <= 1'b0;
      if (sys_rst)
      begin
         ph <= 2'h0;
         pc <= 16'h1000;
         in_brk <= 1'b0;
      end
      else if (in_brk && leave)
      begin
         in_brk <= 1'b0;
         cpu_rti <= 1'b1;
      end
      else if (!in_brk)
      begin
         ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
         pc <= (ph == 2'h2) ? pc + 16'h0001 : pc;
         // a halted core sits on a boundary every cycle
         in_brk <= ((ph == 2'h2) || halt) && break_req;
      end
   end
endmodule : abu_cpu_model

// ### dv/testbench.sv
// self-checking bench of the address breakpoint unit
`include "abu_consts.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, sys_rst, reg_wr, reg_rd, cpu_fetch, cpu_last_cycle, cpu_rti, cpu_in_wait, cpu_in_stop;
   logic monitor_mode, tlv, leave, lpw_seen, break_req, lpw, tstop, wdis, sca, irq;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, opc, v;
   logic [15:0] cpu_addr, vec;
   int err_total, n_checks, cyc;
   abu_break_unit DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_addr(cpu_addr), .cpu_fetch(cpu_fetch),
      .cpu_last_cycle(cpu_last_cycle), .cpu_rti(cpu_rti), .cpu_in_wait(cpu_in_wait), .cpu_in_stop(cpu_in_stop),
      .monitor_mode(monitor_mode), .test_level_voltage(tlv), .break_req(break_req),
      .software_interrupt_opcode(opc), .break_vector(vec), .low_power_wake(lpw), .timer_counters_stop(tstop),
      .watchdog_disable(wdis), .status_clear_allow(sca), .irq(irq));
   abu_cpu_model cpu (.clk(clk), .sys_rst(sys_rst), .break_req(break_req), .leave(leave),
      .halt(cpu_in_wait || cpu_in_stop), .cpu_addr(cpu_addr),
      .cpu_fetch(cpu_fetch), .cpu_last_cycle(cpu_last_cycle), .cpu_rti(cpu_rti));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task wrap_up;
      if (err_total == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   always @(posedge clk)
   begin
      cyc++;
      if (lpw === 1'b1)
         lpw_seen = 1'b1;
      if (cyc == 3000)
      begin
         err_total++;
         wrap_up();
      end
   end
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask : chk
   task wr(input logic [2:0] ad, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [2:0] ad);
      @(posedge clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   task wait_stop(input logic e);
      #1;
      for (int i = 0; i < 100 && tstop !== e; i++)
         @(posedge clk) #1;
      chk("timer_counters_stop", e, tstop);
   endtask : wait_stop
   task leave_brk;
      wr(`ABU_OFS_CTRL, 8'h00);
      @(posedge clk) leave <= 1'b1;
      @(posedge clk) leave <= 1'b0;
      wait_stop(1'b0);
   endtask : leave_brk
   initial
   begin
      {sys_rst, reg_wr, reg_rd, cpu_in_wait, cpu_in_stop, monitor_mode, tlv, leave, lpw_seen} = 9'h100;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      // reset values, unmapped index reads zero
      foreach (v[i])
      begin
         if (i > 4 && i < 7) continue;
         rd(3'(i));
         chk("reset_value", 16'h0000, v);
      end
      // address match break
      tlv <= 1'b1;
      wr(`ABU_OFS_ADRH, 8'h10);
      wr(`ABU_OFS_ADRL, 8'h10);
      wr(`ABU_OFS_CTRL, 8'h80);
      wait_stop(1'b1);
      chk("break_vector", `ABU_VEC_NORMAL, vec);
      chk("opcode", `ABU_SWI_OPCODE, opc);
      chk("watchdog_disable", 16'h1, wdis);
      chk("status_clear_allow", 16'h0, sca);
      rd(`ABU_OFS_CTRL);
      chk("ctrl", 16'hC0, v);
      wr(`ABU_OFS_FCLR, 8'h80);
      #1 chk("status_clear_allow", 16'h1, sca);
      rd(`ABU_OFS_IRQS);
      chk("irq_status", 16'h3, v[1:0]);
      wr(`ABU_OFS_IRQM, 8'h00);
      #1 chk("irq_masked", 16'h0, irq);
      wr(`ABU_OFS_IRQM, 8'h07);
      #1 chk("irq_unmasked", 16'h1, irq);
      leave_brk();
      rd(`ABU_OFS_CTRL);
      chk("ctrl", 16'h00, v);
      wr(`ABU_OFS_IRQS, 8'h07);
      rd(`ABU_OFS_IRQS);
      chk("irq_status", 16'h00, v);
      chk("irq", 16'h0, irq);
      // software break out of wait, monitor vector
      {monitor_mode, cpu_in_wait, tlv} <= 3'b110;
      lpw_seen = 1'b0;
      wr(`ABU_OFS_CTRL, 8'h40);
      wait_stop(1'b1);
      chk("break_vector", `ABU_VEC_MONITOR, vec);
      chk("watchdog_disable", 16'h0, wdis);
      chk("low_power_wake", 16'h1, lpw_seen);
      rd(`ABU_OFS_WAKE);
      chk("break_wait", 16'h1, v[`ABU_BIT_WAIT]);
      wr(`ABU_OFS_WAKE, 8'h00);
      rd(`ABU_OFS_WAKE);
      chk("break_wait", 16'h0, v[`ABU_BIT_WAIT]);
      cpu_in_wait <= 1'b0;
      leave_brk();
      // software break out of stop
      cpu_in_stop <= 1'b1;
      lpw_seen = 1'b0;
      wr(`ABU_OFS_CTRL, 8'h40);
      wait_stop(1'b1);
      chk("low_power_wake", 16'h1, lpw_seen);
      rd(`ABU_OFS_WAKE);
      chk("low_power_exit", 16'h1, v[`ABU_BIT_LPEXIT]);
      cpu_in_stop <= 1'b0;
      leave_brk();
      wrap_up();
   end
endmodule : testbench
